// ---- bench/tap_checker.sv ----
// Concurrent checks on the test port pins and the ring controls
`timescale 1ns/10ps
`default_nettype none
module tap_checker
    import tap_pkg::*;
#(
    parameter int BSR_LEN = 89
) (
    // Clocks and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic tck,
    // Test port pins
    input wire logic tms,
    input wire logic tdo,
    input wire logic tdo_oe_n,
    // Ring controls
    input wire logic [BSR_LEN-2:0] ring_drive,
    input wire logic ring_override,
    input wire logic q_bus_float
);
    logic tck_reg;
    logic [5:0] quiet_reg;
    logic [5:0] quiet_next;
    // Saturating count of memory cycles with the test clock at rest
    always_comb
    begin
        quiet_next = quiet_reg;
        if (!reset_n || tck != tck_reg)
            quiet_next = 6'h00;
        else if (quiet_reg != 6'h3f)
            quiet_next = quiet_reg + 6'h01;
    end
    always_ff @(posedge ref_clk)
    begin
        tck_reg <= tck;
        quiet_reg <= quiet_next;
    end
    sequence five_high;
        tms [*5];
    endsequence
    // Output pins move only while the test clock is low
    tdo_edge_a: assert property (@(posedge ref_clk) disable iff (!reset_n) !$stable(tdo) |-> !tck)
        else $error("tdo moved on a rising test clock");
    oe_edge_a: assert property (@(posedge ref_clk) disable iff (!reset_n) !$stable(tdo_oe_n) |-> !tck)
        else $error("tdo enable moved on a rising test clock");
    // Five high mode-select edges park the port away from shifting
    tap_reset_a: assert property (@(posedge tck) disable iff (!reset_n) five_high |=> tdo_oe_n [*2])
        else $error("port shifting right after the reset sequence");
    shift_exit_a: assert property (@(posedge tck) disable iff (!reset_n) $rose(tdo_oe_n) |-> tdo_oe_n [*3])
        else $error("shift re-entered too soon after exit");
    shift_entry_a: assert property (@(posedge tck) disable iff (!reset_n) $fell(tdo_oe_n) |-> !$past(tms))
        else $error("tdo driven without a shift entry");
    // Sync reset clears every ring control on the next edge
    ring_reset_a: assert property (@(posedge ref_clk) !reset_n |=> !ring_override && !q_bus_float && ring_drive == '0)
        else $error("ring controls not cleared by reset");
    // Ring controls only follow test clock activity
    ring_quiet_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        quiet_reg == 6'h3f |-> $stable(ring_drive) && $stable(ring_override) && $stable(q_bus_float))
        else $error("ring controls changed with the test clock at rest");
    idle_float_a: assert property (@(posedge ref_clk) disable iff (!reset_n) quiet_reg > 6'h06 |-> tdo_oe_n)
        else $error("tdo driven while the test clock rests");
endmodule // tap_checker
bind sram_boundary_scan_tap tap_checker #(.BSR_LEN(BSR_LEN)) tap_checker_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
    .ring_drive(ring_drive), .ring_override(ring_override), .q_bus_float(q_bus_float)
);
`default_nettype wire

// ---- bench/tap_host_model.sv ----
// Board-side test controller model driving the serial test port
`timescale 1ns/10ps
`default_nettype none
module tap_host_model (
    // Serial test port
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe_n
);
    int oe_errs;
    // Pulled-up lines rest high; clock rests low between frames
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        oe_errs = 0;
    end
    // One period; tdo is taken just before the rise
    task automatic step(input logic m, input logic d, output logic o, output logic oe_n);
        tms = m;
        tdi = d;
        #7.5;
        o = tdo;
        oe_n = tdo_oe_n;
        tck = 1'b1;
        #7.5;
        tck = 1'b0;
    endtask
    task automatic idle(input int n, input logic m);
        logic o;
        logic oe_n;
        repeat (n) step(m, 1'b1, o, oe_n);
    endtask
    // Five mode-select highs, then park in idle
    task automatic reset_tap();
        idle(5, 1'b1);
        idle(1, 1'b0);
    endtask
    // Scan n bits LSB first through IR or DR path from idle, then update
    task automatic scan(input logic ir, input int n, input logic [127:0] din, output logic [127:0] dout);
        logic o;
        logic oe_n;
        dout = '0;
        idle(ir ? 2 : 1, 1'b1);
        idle(2, 1'b0);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], o, oe_n);
            dout[i] = o;
            if (oe_n !== 1'b0)
                oe_errs++;
        end
        tdi = 1'b1;
        idle(1, 1'b1);
        idle(1, 1'b0);
    endtask
endmodule // tap_host_model
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench for the boundary-scan test port
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import tap_pkg::*;
    localparam logic [31:0] ID_VAL = 32'h2468_ACE0; // Arbitrary value, bit 0 left clear on purpose
    typedef struct { instr_t code; int len; logic ovr; logic flt; } row_s;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic tck, tms, tdi, tdo, tdo_oe_n, ring_override, q_bus_float;
    logic [87:0] ring_in = '0;
    logic [87:0] ring_drive;
    logic [87:0] pre_exp = '0;
    logic cell_exp = 1'b1;
    logic [127:0] din, dout, exp_v;
    int n_fail = 0;
    int checks_done = 0;
    // Code, path length, expected override and float
    // Reserved codes never loaded by the controller
    row_s rows[8] = '{'{3'h0, 89, 1, 0}, '{3'h1, 32, 0, 0}, '{3'h2, 89, 0, 1}, '{3'h7, 1, 0, 0},
                      '{3'h4, 89, 0, 0}, '{3'h1, 32, 0, 0}, '{3'h4, 89, 0, 0}, '{3'h7, 1, 0, 0}};
    always #2 ref_clk = ~ref_clk;
    sram_boundary_scan_tap #(.ID_CODE(ID_VAL), .BSR_LEN(89)) sram_boundary_scan_tap_inst (
        .ref_clk(ref_clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe_n(tdo_oe_n), .ring_in(ring_in), .ring_drive(ring_drive),
        .ring_override(ring_override), .q_bus_float(q_bus_float)
    );
    tap_host_model tap_host_model_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n));
    task automatic chk_vec(input string what, input logic [127:0] e, input logic [127:0] g);
        checks_done++;
        if (g !== e)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chk_bit(input string what, input logic e, input logic g);
        checks_done++;
        if (g !== e)
        begin
            n_fail++;
            $display("MISMATCH %s expected %b seen %b", what, e, g);
        end
    endtask
    // Let the crossing settle, then compare the ring controls
    task automatic chk_ring(input logic ovr, input logic flt);
        tap_host_model_inst.idle(16, 1'b0);
        @(negedge ref_clk);
        chk_bit("ring_override", ovr, ring_override);
        chk_bit("q_bus_float", flt, q_bus_float);
        chk_vec("ring_drive", 128'(pre_exp), 128'(ring_drive));
    endtask
    task automatic finish_test();
        $display("Compared %0d values, %0d mismatches", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Watchdog: the sequence needs about 24 us
    initial
    begin
        #100_000;
        n_fail++;
        finish_test();
    end
    initial
    begin
        fork
            tap_host_model_inst.idle(12, 1'b1);
            begin
                repeat (20) @(negedge ref_clk);
                chk_bit("oe_n_in_reset", 1'b1, tdo_oe_n);
                chk_bit("float_in_reset", 1'b0, q_bus_float);
                reset_n = 1'b1;
            end
        join
        tap_host_model_inst.reset_tap();
        // Each defined code: IR capture pattern, path through tdi/tdo, ring effect
        for (int r = 0; r < 8; r++)
        begin
            @(negedge ref_clk);
            ring_in = {11{8'h35 ^ r[7:0]}};
            tap_host_model_inst.idle(6, 1'b0);
            tap_host_model_inst.scan(1'b1, 3, {125'h0, rows[r].code}, dout);
            chk_vec("ir_capture", 128'h1, {126'h0, dout[1:0]});
            din = 128'hF0E1_D2C3_B4A5_9687_7869_5A4B_3C2D_1E0F ^ (128'(r) << 64);
            din[127] = 1'b1;
            tap_host_model_inst.scan(1'b0, 128, din, dout);
            case (rows[r].len)
                1: exp_v = din << 1;
                32: exp_v = (din << 32) | 128'(ID_VAL | 32'h1);
                default: exp_v = (din << 89) | 128'({cell_exp, ring_in});
            endcase
            chk_vec("dr_scan", exp_v, dout);
            if (rows[r].len == 89)
            begin
                pre_exp = din[126:39];
                cell_exp = din[127];
            end
            chk_ring(rows[r].ovr, rows[r].flt);
        end
        // External test with the drive cell cleared floats the bus
        tap_host_model_inst.scan(1'b1, 3, 128'h0, dout);
        din = 128'h0FED_CBA9_8765_4321_0F1E_2D3C_4B5A_6978;
        tap_host_model_inst.scan(1'b0, 128, din, dout);
        pre_exp = din[126:39];
        chk_ring(1'b1, 1'b1);
        // Port reset restores identification and presets the cell
        tap_host_model_inst.reset_tap();
        chk_ring(1'b0, 1'b0);
        tap_host_model_inst.scan(1'b0, 32, 128'h0, dout);
        chk_vec("id_after_reset", 128'(ID_VAL | 32'h1), dout);
        tap_host_model_inst.scan(1'b1, 3, 128'h0, dout);
        chk_ring(1'b1, 1'b0);
        // Test clock at rest so the idle checks see a quiet port
        repeat (80) @(negedge ref_clk);
        chk_bit("oe_n_at_rest", 1'b1, tdo_oe_n);
        chk_bit("shift_enable", 1'b1, tap_host_model_inst.oe_errs == 0);
        finish_test();
    end
endmodule // tb_top
`default_nettype wire

// ---- hw/sram_boundary_scan_tap.sv ----
// Boundary-scan test port of the burst SRAM: registers, scan path and I/O ring control
`timescale 1ns/10ps
`default_nettype none
`include "tap_consts.svh"
module sram_boundary_scan_tap
    import tap_pkg::*;
#(
    // Identification value is arbitrary; bit 0 is forced to one
    parameter logic [`ID_WIDTH-1:0] ID_CODE = 32'h1357_9BDE,
    parameter int BSR_LEN = `BSR_LEN
) (
    // System clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Test port pins
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe_n,
    // I/O ring towards the memory core
    input wire logic [BSR_LEN-2:0] ring_in,
    output logic [BSR_LEN-2:0] ring_drive,
    output logic ring_override,
    output logic q_bus_float
);
    // Scan register map
    //   Top bit is the drive control cell, the rest mirror the ring
    //   Ring half is a snapshot carried over from the memory clock,
    //   so a capture may see a value a few test clocks old
    //   Hold the ring steady for about ten test clocks before capture
    //
    // Clocking
    //   Test side runs on the test clock alone
    //   Memory side sees only registered, handshaken ring controls
    //   Control word crosses as one unit, so override, float and drive
    //   values never arrive out of step with each other
    //
    // Power-up
    //   Port reset follows reset_n and needs test clock edges meanwhile
    //   A board that ties the test clock low never resets the port,
    //   which is harmless: the ring controls then stay released
    //
    // Limitation
    //   Back-to-back updates closer than one handshake round are merged;
    //   the memory side only ever sees the latest pattern
    localparam int CTRL = BSR_LEN - 1;
    localparam int RING = BSR_LEN - 1;
    localparam int OUT_W = BSR_LEN + 1;

    // Reset crossing into the test clock domain
    logic [`SYNC_STAGES-1:0] rst_sync_reg;
    logic [`SYNC_STAGES-1:0] rst_sync_next;
    logic tap_rst_n_reg;
    logic tap_rst_n_next;

    // Instruction path
    instr_t ir_shift_reg;
    instr_t ir_shift_next;
    instr_t ir_reg;
    instr_t ir_next;

    // Data registers
    logic bypass_reg;
    logic bypass_next;
    logic [`ID_WIDTH-1:0] id_reg;
    logic [`ID_WIDTH-1:0] id_next;
    logic [BSR_LEN-1:0] bsr_reg;
    logic [BSR_LEN-1:0] bsr_next;
    logic [BSR_LEN-1:0] preload_reg;
    logic [BSR_LEN-1:0] preload_next;

    // Serial output, on the falling edge
    logic tdo_reg;
    logic tdo_next;
    logic tdo_oe_n_reg;
    logic tdo_oe_n_next;

    // Selection and crossings
    logic sel_bsr;
    logic sel_id;
    logic sel_bypass;
    logic [RING-1:0] ring_shadow;
    logic [OUT_W-1:0] ctrl_word_tck;
    logic [OUT_W-1:0] ctrl_word_ref;
    logic tck_override;
    logic tck_float;

    // System-side output registers
    logic [RING-1:0] ring_drive_reg;
    logic [RING-1:0] ring_drive_next;
    logic ring_override_reg;
    logic ring_override_next;
    logic q_bus_float_reg;
    logic q_bus_float_next;

    tap_ctrl_if ctl ();

    // A change of reset counts once the second and third stages agree
    always_comb
    begin
        rst_sync_next = {rst_sync_reg[`SYNC_STAGES-2:0], reset_n};
        tap_rst_n_next = tap_rst_n_reg;
        if (rst_sync_reg[1] == rst_sync_reg[2])
            tap_rst_n_next = rst_sync_reg[2];
    end

    // No reset of its own: this is the reset; needs test clock edges while reset_n is low
    always_ff @(posedge tck)
    begin
        rst_sync_reg <= rst_sync_next;
        tap_rst_n_reg <= tap_rst_n_next;
    end

    tap_fsm u_fsm (
        .tck(tck),
        .tap_rst_n(tap_rst_n_reg),
        .tms(tms),
        .ctl(ctl)
    );

    // Ring levels from the memory clock towards the test clock
    word_cdc #(
        .WIDTH(RING)
    ) u_ring_cdc (
        .src_clk(ref_clk),
        .src_rst_n(reset_n),
        .src_data(ring_in),
        .dst_clk(tck),
        .dst_rst_n(tap_rst_n_reg),
        .dst_data(ring_shadow)
    );

    // Exactly one register on the scan path; reserved codes fall back to bypass
    // Bypass as the fallback keeps the chain length defined
    // even if a controller loads a code it should not
    always_comb
    begin
        sel_bsr = (ir_reg == `INSTR_EXTEST) || (ir_reg == `INSTR_SAMPLE) || (ir_reg == `INSTR_SAMPLEZ);
        sel_id = (ir_reg == `INSTR_IDCODE);
        sel_bypass = !sel_bsr && !sel_id;
    end

    // Instruction shift and update
    always_comb
    begin
        ir_shift_next = ir_shift_reg;
        ir_next = ir_reg;
        if (ctl.test_reset)
        begin
            ir_next = `IR_RESET;
        end
        else
        begin
            if (ctl.capture_ir)
                ir_shift_next = `IR_CAPTURE_PAT;
            if (ctl.shift_ir)
                ir_shift_next = {tdi, ir_shift_reg[`IR_WIDTH-1:1]};
            if (ctl.update_ir)
                ir_next = ir_shift_reg;
        end
    end

    always_ff @(posedge tck)
    begin
        if (!tap_rst_n_reg)
        begin
            ir_shift_reg <= `IR_CAPTURE_PAT;
            ir_reg <= `IR_RESET;
        end
        else
        begin
            ir_shift_reg <= ir_shift_next;
            ir_reg <= ir_next;
        end
    end

    // Data register capture, shift and update
    // Only the selected register moves; the others keep their contents
    // Preload survives a port reset except for the control cell
    always_comb
    begin
        bypass_next = bypass_reg;
        id_next = id_reg;
        bsr_next = bsr_reg;
        preload_next = preload_reg;
        if (ctl.test_reset)
        begin
            preload_next[CTRL] = `CTRL_CELL_RESET;
        end
        if (ctl.capture_dr)
        begin
            if (sel_bypass)
                bypass_next = 1'b0;
            if (sel_id)
            begin
                id_next = ID_CODE;
                id_next[`ID_PRESENT_BIT] = 1'b1;
            end
            // Control cell reads back its latched value
            if (sel_bsr)
                bsr_next = {preload_reg[CTRL], ring_shadow};
        end
        if (ctl.shift_dr)
        begin
            if (sel_bypass)
                bypass_next = tdi;
            if (sel_id)
                id_next = {tdi, id_reg[`ID_WIDTH-1:1]};
            // Captured bits leave at the low end while the new pattern fills from the top
            if (sel_bsr)
                bsr_next = {tdi, bsr_reg[BSR_LEN-1:1]};
        end
        if (ctl.update_dr && sel_bsr)
        begin
            preload_next = bsr_reg;
        end
    end

    always_ff @(posedge tck)
    begin
        if (!tap_rst_n_reg)
        begin
            bypass_reg <= 1'b0;
            id_reg <= '0;
            bsr_reg <= '0;
            preload_reg <= {`CTRL_CELL_RESET, {RING{1'b0}}};
        end
        else
        begin
            bypass_reg <= bypass_next;
            id_reg <= id_next;
            bsr_reg <= bsr_next;
            preload_reg <= preload_next;
        end
    end

    // Serial output only while shifting; other states float the pin
    always_comb
    begin
        tdo_next = tdo_reg;
        tdo_oe_n_next = 1'b1;
        if (ctl.shift_ir)
        begin
            tdo_next = ir_shift_reg[0];
            tdo_oe_n_next = 1'b0;
        end
        else if (ctl.shift_dr)
        begin
            tdo_oe_n_next = 1'b0;
            if (sel_bsr)
                tdo_next = bsr_reg[0];
            else if (sel_id)
                tdo_next = id_reg[0];
            else
                tdo_next = bypass_reg;
        end
    end

    // Falling edge gives the far end half a period of setup
    always_ff @(negedge tck)
    begin
        if (!tap_rst_n_reg)
        begin
            tdo_reg <= 1'b0;
            tdo_oe_n_reg <= 1'b1;
        end
        else
        begin
            tdo_reg <= tdo_next;
            tdo_oe_n_reg <= tdo_oe_n_next;
        end
    end

    // Ring control follows the current instruction and the preload register only
    // Computed from registered state, so the crossing sees no glitches
    always_comb
    begin
        tck_override = (ir_reg == `INSTR_EXTEST);
        tck_float = (ir_reg == `INSTR_SAMPLEZ)
            || ((ir_reg == `INSTR_EXTEST) && !preload_reg[CTRL]);
        ctrl_word_tck = {tck_override, tck_float, preload_reg[RING-1:0]};
    end

    // Ring control from the test clock towards the memory clock
    word_cdc #(
        .WIDTH(OUT_W)
    ) u_ctrl_cdc (
        .src_clk(tck),
        .src_rst_n(tap_rst_n_reg),
        .src_data(ctrl_word_tck),
        .dst_clk(ref_clk),
        .dst_rst_n(reset_n),
        .dst_data(ctrl_word_ref)
    );

    // One more register so the core sees clean flops; memory runs untouched unless overridden or its Q bus floated
    always_comb
    begin
        ring_drive_next = ctrl_word_ref[RING-1:0];
        q_bus_float_next = ctrl_word_ref[RING];
        ring_override_next = ctrl_word_ref[RING+1];
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            ring_drive_reg <= '0;
            q_bus_float_reg <= 1'b0;
            ring_override_reg <= 1'b0;
        end
        else
        begin
            ring_drive_reg <= ring_drive_next;
            q_bus_float_reg <= q_bus_float_next;
            ring_override_reg <= ring_override_next;
        end
    end

    // Outputs, each straight from a flip-flop
    // Enable is active low: the pin is driven only while it reads zero
    assign tdo = tdo_reg;
    assign tdo_oe_n = tdo_oe_n_reg;
    assign ring_drive = ring_drive_reg;
    assign ring_override = ring_override_reg;
    assign q_bus_float = q_bus_float_reg;
endmodule // sram_boundary_scan_tap
`default_nettype wire

// ---- hw/tap_fsm.sv ----
// Sixteen-state test port controller
`timescale 1ns/10ps
`default_nettype none
module tap_fsm
    import tap_pkg::*;
(
    // Test clock domain
    input wire logic tck,
    input wire logic tap_rst_n,
    input wire logic tms,
    // Decoded states
    tap_ctrl_if.fsm ctl
);
    tap_state_e state_reg;
    tap_state_e state_next;

    // Next state from mode select on each rising edge
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            tlr_st: state_next = tms ? tlr_st : rti_st;
            rti_st: state_next = tms ? sel_dr_st : rti_st;
            sel_dr_st: state_next = tms ? sel_ir_st : cap_dr_st;
            cap_dr_st: state_next = tms ? ex1_dr_st : sh_dr_st;
            sh_dr_st: state_next = tms ? ex1_dr_st : sh_dr_st;
            ex1_dr_st: state_next = tms ? upd_dr_st : pa_dr_st;
            pa_dr_st: state_next = tms ? ex2_dr_st : pa_dr_st;
            ex2_dr_st: state_next = tms ? upd_dr_st : sh_dr_st;
            upd_dr_st: state_next = tms ? sel_dr_st : rti_st;
            sel_ir_st: state_next = tms ? tlr_st : cap_ir_st;
            cap_ir_st: state_next = tms ? ex1_ir_st : sh_ir_st;
            sh_ir_st: state_next = tms ? ex1_ir_st : sh_ir_st;
            ex1_ir_st: state_next = tms ? upd_ir_st : pa_ir_st;
            pa_ir_st: state_next = tms ? ex2_ir_st : pa_ir_st;
            ex2_ir_st: state_next = tms ? upd_ir_st : sh_ir_st;
            upd_ir_st: state_next = tms ? sel_dr_st : rti_st;
        endcase
    end

    // Five high samples reach reset from any state
    always_ff @(posedge tck)
    begin
        if (!tap_rst_n)
            state_reg <= tlr_st;
        else
            state_reg <= state_next;
    end

    // State decodes for the core
    assign ctl.test_reset = (state_reg == tlr_st);
    assign ctl.capture_ir = (state_reg == cap_ir_st);
    assign ctl.shift_ir = (state_reg == sh_ir_st);
    assign ctl.update_ir = (state_reg == upd_ir_st);
    assign ctl.capture_dr = (state_reg == cap_dr_st);
    assign ctl.shift_dr = (state_reg == sh_dr_st);
    assign ctl.update_dr = (state_reg == upd_dr_st);
endmodule // tap_fsm
`default_nettype wire

// ---- hw/word_cdc.sv ----
// Toggle handshake carrying a word between two clock domains
`timescale 1ns/10ps
`default_nettype none
`include "tap_consts.svh"
module word_cdc #(
    parameter int WIDTH = 8
) (
    // Source domain
    input wire logic src_clk,
    input wire logic src_rst_n,
    input wire logic [WIDTH-1:0] src_data,
    // Destination domain
    input wire logic dst_clk,
    input wire logic dst_rst_n,
    output logic [WIDTH-1:0] dst_data
);
    logic [WIDTH-1:0] hold_reg, hold_next;
    logic req_reg, req_next;
    logic [`SYNC_STAGES-1:0] ack_sync_reg, ack_sync_next;
    logic [WIDTH-1:0] data_reg, data_next;
    logic ack_reg, ack_next;
    logic [`SYNC_STAGES-1:0] req_sync_reg, req_sync_next;

    // Source reloads only once the last word is acknowledged, so hold is stable while read
    always_comb
    begin
        hold_next = hold_reg;
        req_next = req_reg;
        ack_sync_next = {ack_sync_reg[`SYNC_STAGES-2:0], ack_reg};
        if ((ack_sync_reg[1] == ack_sync_reg[2]) && (ack_sync_reg[2] == req_reg))
        begin
            hold_next = src_data;
            req_next = ~req_reg;
        end
    end

    always_ff @(posedge src_clk)
    begin
        if (!src_rst_n)
        begin
            hold_reg <= '0;
            req_reg <= 1'b0;
            ack_sync_reg <= '0;
        end
        else
        begin
            hold_reg <= hold_next;
            req_reg <= req_next;
            ack_sync_reg <= ack_sync_next;
        end
    end

    // Destination takes the word once the request has settled
    always_comb
    begin
        data_next = data_reg;
        ack_next = ack_reg;
        req_sync_next = {req_sync_reg[`SYNC_STAGES-2:0], req_reg};
        if ((req_sync_reg[1] == req_sync_reg[2]) && (req_sync_reg[2] != ack_reg))
        begin
            data_next = hold_reg;
            ack_next = req_sync_reg[2];
        end
    end

    always_ff @(posedge dst_clk)
    begin
        if (!dst_rst_n)
        begin
            data_reg <= '0;
            ack_reg <= 1'b0;
            req_sync_reg <= '0;
        end
        else
        begin
            data_reg <= data_next;
            ack_reg <= ack_next;
            req_sync_reg <= req_sync_next;
        end
    end

    assign dst_data = data_reg;
endmodule // word_cdc
`default_nettype wire

// ---- shared/tap_consts.svh ----
// Constants of the boundary-scan test port
`ifndef TAP_CONSTS_SVH
`define TAP_CONSTS_SVH
// Contract
// - Five TMS-high edges reset test logic only
// - Sample inputs on rising, drive TDO falling
// - Reset at power-up; TDO driven only shifting
// - Data enters at MSB, leaves at LSB
// - Instruction selects exactly one scan register
// - Three-bit IR, IDCODE at reset
// - Capture-IR loads 01 into low bits
// - One-bit bypass, captured as zero
// - Boundary register captures ring, then shifts
// - IDCODE captures hardwired 32-bit code, shifts
// - New instruction acts only at Update-IR
// - SAMPLE Z floats outputs until next update
// - SAMPLE/PRELOAD snapshots pins, memory unaffected
// - Update-DR latches shifted pattern into preload
// - Captured data out while preload shifts in
// - BYPASS shifts through the single bypass bit
// - EXTEST drives preload values onto pins
// - Cell 89 enables or floats output drivers
// - Cell 89 preset to one at reset
// - Codes 000 EXTEST, 001 IDCODE, 010 SAMPLEZ
// - Code 100 SAMPLE, 111 BYPASS, rest reserved
// - Identification bit 0 always reads one
`define IR_WIDTH 3
`define IR_CAPTURE_PAT 3'b001
`define INSTR_EXTEST 3'b000
`define INSTR_IDCODE 3'b001
`define INSTR_SAMPLEZ 3'b010
`define INSTR_SAMPLE 3'b100
`define INSTR_BYPASS 3'b111
`define IR_RESET `INSTR_IDCODE
`define ID_WIDTH 32
`define ID_PRESENT_BIT 0
`define BSR_LEN 89
`define CTRL_CELL (`BSR_LEN - 1)
`define CTRL_CELL_RESET 1'b1
`define SYNC_STAGES 3
`endif

// ---- shared/tap_ctrl_if.sv ----
// Decoded controller states passed from the state machine to the core
`timescale 1ns/10ps
`default_nettype none
interface tap_ctrl_if;
    logic test_reset;
    logic capture_ir;
    logic shift_ir;
    logic update_ir;
    logic capture_dr;
    logic shift_dr;
    logic update_dr;
    modport fsm (output test_reset, capture_ir, shift_ir, update_ir, capture_dr, shift_dr, update_dr);
    modport core (input test_reset, capture_ir, shift_ir, update_ir, capture_dr, shift_dr, update_dr);
endinterface
`default_nettype wire

// ---- shared/tap_pkg.sv ----
// Types shared by the test port modules
`default_nettype none
package tap_pkg;
    `include "tap_consts.svh"
    typedef enum {
        tlr_st, rti_st,
        sel_dr_st, cap_dr_st, sh_dr_st, ex1_dr_st, pa_dr_st, ex2_dr_st, upd_dr_st,
        sel_ir_st, cap_ir_st, sh_ir_st, ex1_ir_st, pa_ir_st, ex2_ir_st, upd_ir_st
    } tap_state_e;
    typedef logic [`IR_WIDTH-1:0] instr_t;
endpackage
`default_nettype wire
